// >>> inc/sch_pkg.sv
// Constants for the speech codec homing control block.
// Assumes 16-bit sample and parameter words.
package sch_pkg;
  localparam int FRAME_SAMPLES = 160;
  localparam int SAMPLE_BITS = 13;
  localparam int WORD_BITS = 16;
  localparam logic [15:0] ENC_HOME_WORD = 16'h0008;
  localparam int FRAME_BITS = 244;
  localparam int PARAM_WORDS = 57;
  // Spectral words plus first subframe words
  localparam int EARLY_WORDS = 18;
  localparam logic [15:0] LSP_HOME = 16'h7530;      // 30000
  localparam logic [15:0] GAIN_PRED_HOME = 16'hF6B3; // -2381
  localparam logic [31:0] NOISE_SEED_HOME = 32'h70816958;
  localparam logic [15:0] AGC_HOME = 16'h1000;       // 4096
  // Decoder-direction homing frame, in stream order
  localparam logic [0:56][15:0] DEC_HOME_FRAME = {
    16'h0004, 16'h002F, 16'h00B4, 16'h0090, 16'h003E,
    16'h0156, 16'h000B,
    16'h0000, 16'h0001, 16'h000F, 16'h0001, 16'h000D,
    16'h0000, 16'h0008, 16'h0000, 16'h0005, 16'h0000, 16'h0003,
    16'h0036, 16'h0001,
    16'h0001, 16'h0000, 16'h0000, 16'h0001, 16'h0001,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0156, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0036, 16'h000B,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
endpackage

// >>> design/sch_homing.sv
// Homing detection and home-state control for encoder and decoder paths.
// Assumes inputs synchronous to clk_in and whole frames framed by the datapath.
`timescale 1ns/10ps

// Notes on behaviour
// - Encoder homing frame: 160 equal 13-bit samples, only LSB set.
// - Left-justified in 16-bit words each sample equals 0008 hex.
// - Second and later consecutive decoder homing frames yield encoder homing pattern.
// - Decoder homing frame is one fixed parameter set, starting 0004, 002F, 00B4.
// - Encoder pattern counts only when aligned with internal frame boundaries.
// - Encoder homing frame is first processed and emitted as an ordinary frame.
// - From home state the emitted parameter frame equals the decoder homing frame.
// - After the homing frame the whole encoder returns to home state.
// - Decoder homing frame decoded normally; from home, output replaced by encoder pattern.
// - After that frame the whole decoder returns to home state.
// - In home, decoder may detect homing from spectral and first-subframe words only.
// - Encoder home: memories zero, spectral history 30000, gain -2381, seed 70816958.
// - Parameter frame is 244 bits for 20 ms; decoder detects per frame.
// - Decoder home loads gain-control memory 4096, other memories cleared.
module sch_homing (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [15:0] enc_sample_in,
  input wire logic enc_sample_valid_in,
  input wire logic enc_frame_start_in,
  input wire logic [15:0] enc_param_in,
  input wire logic enc_param_valid_in,
  input wire logic enc_param_first_in,
  input wire logic [15:0] dec_param_in,
  input wire logic dec_param_valid_in,
  input wire logic dec_param_first_in,
  input wire logic [15:0] dec_sample_in,
  input wire logic dec_sample_valid_in,
  input wire logic dec_sample_first_in,
  output logic [15:0] enc_param_out,
  output logic enc_param_valid_out,
  output logic enc_homing_detect_out,
  output logic enc_home_reset_out,
  output logic enc_in_home_out,
  output logic [15:0] enc_lsp_home_out,
  output logic [15:0] enc_gain_mem_home_out,
  output logic [31:0] noise_seed_out,
  output logic [15:0] dec_sample_out,
  output logic dec_sample_valid_out,
  output logic dec_homing_detect_out,
  output logic dec_early_detect_out,
  output logic dec_home_reset_out,
  output logic dec_in_home_out,
  output logic [15:0] dec_agc_home_out
);

  typedef struct packed {
    logic [7:0] enc_cnt;
    logic enc_match;
    logic enc_aligned;
    logic enc_home;
    logic enc_home_start;
    logic enc_hf;
    logic enc_subst;
    logic enc_detect;
    logic [5:0] enc_pcnt;
    logic [15:0] enc_param;
    logic enc_pvalid;
    logic enc_plast;
    logic enc_rst;
    logic [15:0] enc_lsp;
    logic [15:0] enc_gain;
    logic [31:0] seed;
    logic [5:0] dec_pcnt;
    logic dec_match;
    logic dec_home;
    logic dec_home_start;
    logic dec_hf;
    logic dec_subst;
    logic dec_detect;
    logic dec_early;
    logic [7:0] dec_scnt;
    logic [15:0] dec_sample;
    logic dec_svalid;
    logic dec_slast;
    logic dec_rst;
    logic [15:0] dec_agc;
  } sch_state_t;

  sch_state_t cur;
  sch_state_t next_cur;

  // Parameter word compare against the fixed homing frame
  function automatic logic param_hit(input logic [5:0] idx, input logic [15:0] word);
    param_hit = (idx < 6'(sch_pkg::PARAM_WORDS)) &&
                (word == sch_pkg::DEC_HOME_FRAME[idx]);
  endfunction

  always_comb begin
    logic [5:0] eidx;
    logic [5:0] didx;
    logic ehit;
    logic dhit;
    eidx = 6'h00;
    didx = 6'h00;
    ehit = 1'b0;
    dhit = 1'b0;
    next_cur = cur;
    next_cur.enc_detect = 1'b0;
    next_cur.enc_rst = 1'b0;
    next_cur.enc_pvalid = 1'b0;
    next_cur.enc_plast = 1'b0;
    next_cur.dec_detect = 1'b0;
    next_cur.dec_early = 1'b0;
    next_cur.dec_rst = 1'b0;
    next_cur.dec_svalid = 1'b0;
    next_cur.dec_slast = 1'b0;

    // Encoder input: pattern check over one aligned frame
    if (enc_sample_valid_in) begin
      ehit = (enc_sample_in == sch_pkg::ENC_HOME_WORD);
      if (enc_frame_start_in) begin
        next_cur.enc_cnt = 8'h01;
        next_cur.enc_match = ehit;
        next_cur.enc_aligned = 1'b1;
        next_cur.enc_home_start = cur.enc_home;
        next_cur.enc_home = 1'b0;
      end else if (cur.enc_aligned) begin
        next_cur.enc_cnt = cur.enc_cnt + 8'h01;
        next_cur.enc_match = cur.enc_match & ehit;
      end
      if ((enc_frame_start_in || cur.enc_aligned) &&
          (enc_frame_start_in ? 8'h01 : cur.enc_cnt + 8'h01) ==
          8'(sch_pkg::FRAME_SAMPLES)) begin
        next_cur.enc_aligned = 1'b0;
        if (enc_frame_start_in ? ehit : (cur.enc_match & ehit)) begin
          next_cur.enc_detect = 1'b1;
          next_cur.enc_hf = 1'b1;
          next_cur.enc_subst = enc_frame_start_in ? cur.enc_home : cur.enc_home_start;
        end
      end
    end

    // Encoder output: frame passes normally, forced only from home
    if (enc_param_valid_in) begin
      eidx = enc_param_first_in ? 6'h00 : cur.enc_pcnt;
      next_cur.enc_pcnt = eidx + 6'h01;
      next_cur.enc_pvalid = 1'b1;
      next_cur.enc_plast = (eidx == 6'(sch_pkg::PARAM_WORDS - 1));
      next_cur.enc_param = enc_param_in;
      if (cur.enc_hf && cur.enc_subst && eidx < 6'(sch_pkg::PARAM_WORDS)) begin
        next_cur.enc_param = sch_pkg::DEC_HOME_FRAME[eidx];
      end
    end
    if (cur.enc_pvalid && cur.enc_plast && cur.enc_hf) begin
      next_cur.enc_rst = 1'b1;
      next_cur.enc_hf = 1'b0;
      next_cur.enc_subst = 1'b0;
    end
    if (cur.enc_rst) begin
      next_cur.enc_home = 1'b1;
      next_cur.enc_lsp = sch_pkg::LSP_HOME;
      next_cur.enc_gain = sch_pkg::GAIN_PRED_HOME;
      next_cur.seed = sch_pkg::NOISE_SEED_HOME;
    end

    // Decoder input: per-frame parameter compare
    if (dec_param_valid_in) begin
      didx = dec_param_first_in ? 6'h00 : cur.dec_pcnt;
      dhit = param_hit(didx, dec_param_in);
      next_cur.dec_pcnt = didx + 6'h01;
      if (dec_param_first_in) begin
        next_cur.dec_match = dhit;
        next_cur.dec_home_start = cur.dec_home;
        next_cur.dec_home = 1'b0;
      end else begin
        next_cur.dec_match = cur.dec_match & dhit;
      end
      if (didx == 6'(sch_pkg::EARLY_WORDS - 1) &&
          (dec_param_first_in ? cur.dec_home : cur.dec_home_start) &&
          (cur.dec_match & dhit)) begin
        next_cur.dec_early = 1'b1;
      end
      if (didx == 6'(sch_pkg::PARAM_WORDS - 1) && (cur.dec_match & dhit)) begin
        next_cur.dec_detect = 1'b1;
        next_cur.dec_hf = 1'b1;
        next_cur.dec_subst = cur.dec_home_start;
      end
    end

    // Decoder output: decoded samples, replaced when homed
    if (dec_sample_valid_in) begin
      next_cur.dec_scnt = dec_sample_first_in ? 8'h01 : cur.dec_scnt + 8'h01;
      next_cur.dec_svalid = 1'b1;
      next_cur.dec_slast = ((dec_sample_first_in ? 8'h01 : cur.dec_scnt + 8'h01) ==
                           8'(sch_pkg::FRAME_SAMPLES));
      next_cur.dec_sample = (cur.dec_hf && cur.dec_subst) ?
                            sch_pkg::ENC_HOME_WORD : dec_sample_in;
    end
    if (cur.dec_svalid && cur.dec_slast && cur.dec_hf) begin
      next_cur.dec_rst = 1'b1;
      next_cur.dec_hf = 1'b0;
      next_cur.dec_subst = 1'b0;
    end
    if (cur.dec_rst) begin
      next_cur.dec_home = 1'b1;
      next_cur.dec_agc = sch_pkg::AGC_HOME;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cur <= '0;
      cur.enc_home <= 1'b1;
      cur.dec_home <= 1'b1;
      cur.enc_lsp <= sch_pkg::LSP_HOME;
      cur.enc_gain <= sch_pkg::GAIN_PRED_HOME;
      cur.seed <= sch_pkg::NOISE_SEED_HOME;
      cur.dec_agc <= sch_pkg::AGC_HOME;
    end else begin
      cur <= next_cur;
    end
  end

  assign enc_param_out = cur.enc_param;
  assign enc_param_valid_out = cur.enc_pvalid;
  assign enc_homing_detect_out = cur.enc_detect;
  assign enc_home_reset_out = cur.enc_rst;
  assign enc_in_home_out = cur.enc_home;
  assign enc_lsp_home_out = cur.enc_lsp;
  assign enc_gain_mem_home_out = cur.enc_gain;
  assign noise_seed_out = cur.seed;
  assign dec_sample_out = cur.dec_sample;
  assign dec_sample_valid_out = cur.dec_svalid;
  assign dec_homing_detect_out = cur.dec_detect;
  assign dec_early_detect_out = cur.dec_early;
  assign dec_home_reset_out = cur.dec_rst;
  assign dec_in_home_out = cur.dec_home;
  assign dec_agc_home_out = cur.dec_agc;

endmodule // sch_homing

// >>> verif/sch_homing_properties.sv
// Port-level assertions for the homing block.
// Assumes one clock domain and the synchronous reset rst_in.
`timescale 1ns/10ps
module sch_homing_props (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic enc_param_valid_in,
  input wire logic enc_param_valid_out,
  input wire logic enc_homing_detect_out,
  input wire logic dec_homing_detect_out,
  input wire logic dec_early_detect_out,
  input wire logic enc_home_reset_out,
  input wire logic dec_home_reset_out,
  input wire logic enc_in_home_out,
  input wire logic dec_in_home_out,
  input wire logic [15:0] enc_lsp_home_out,
  input wire logic [15:0] enc_gain_mem_home_out,
  input wire logic [31:0] noise_seed_out,
  input wire logic [15:0] dec_agc_home_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_enc_det_pulse: assert property (enc_homing_detect_out |=> !enc_homing_detect_out)
    else $error("encoder detect wider than one cycle");
  a_dec_det_pulse: assert property (dec_homing_detect_out |=> !dec_homing_detect_out)
    else $error("decoder detect wider than one cycle");
  a_enc_goes_home: assert property (enc_home_reset_out |=> enc_in_home_out)
    else $error("encoder not home after reset pulse");
  a_dec_goes_home: assert property (dec_home_reset_out |=> dec_in_home_out)
    else $error("decoder not home after reset pulse");
  a_enc_home_vals: assert property (enc_home_reset_out |=> noise_seed_out == 32'h70816958
    && enc_lsp_home_out == 16'h7530 && enc_gain_mem_home_out == 16'hF6B3)
    else $error("encoder home values wrong");
  a_dec_agc_val: assert property (dec_home_reset_out |=> dec_agc_home_out == 16'h1000)
    else $error("decoder gain memory home value wrong");
  a_early_left_home: assert property (dec_early_detect_out |-> !dec_in_home_out)
    else $error("early detect while still marked home");
  a_enc_param_lat: assert property (enc_param_valid_in |=> enc_param_valid_out)
    else $error("parameter word not passed on next cycle");
  c_enc_detect: cover property (enc_homing_detect_out);
  c_dec_early: cover property (dec_early_detect_out);
  c_dec_reset: cover property (dec_home_reset_out);
endmodule // sch_homing_props

bind sch_homing sch_homing_props i_sch_homing_props (.*);

// >>> verif/sch_datapath_model.sv
// Datapath stand-in: parameter words and decoded samples on request.
// Assumes one-cycle go pulses from the bench on clk_in.
`timescale 1ns/10ps
module sch_datapath_model (
  input wire logic clk_in,
  input wire logic go_enc_in,
  input wire logic go_dec_in,
  output logic [15:0] enc_param_out,
  output logic enc_param_valid_out,
  output logic enc_param_first_out,
  output logic [15:0] dec_sample_out,
  output logic dec_sample_valid_out,
  output logic dec_sample_first_out
);
  int ne = 0;
  int nd = 0;
  logic [15:0] t = 16'h0000;
  always @(posedge clk_in) begin
    t <= t + 16'h0001;
    ne <= go_enc_in ? 57 : (ne > 0 ? ne - 1 : 0);
    nd <= go_dec_in ? 160 : (nd > 0 ? nd - 1 : 0);
  end
  assign enc_param_valid_out = ne > 0;
  assign enc_param_first_out = ne == 57;
  // Idle lines keep changing
  assign enc_param_out = ne > 0 ? 16'h0055 + 16'(ne) : t;
  assign dec_sample_valid_out = nd > 0;
  assign dec_sample_first_out = nd == 160;
  assign dec_sample_out = nd > 0 ? 16'h1234 : ~t;
endmodule // sch_datapath_model

// >>> verif/sch_homing_bench.sv
// Bench for the homing block with a datapath stand-in.
// Assumes the checker binds itself to the homing block.
`timescale 1ns/10ps
module sch_homing_bench;
  logic clk_in = 0, rst_in = 1, go_enc = 0, go_dec = 0, enc_sample_valid_in = 0;
  logic enc_frame_start_in = 0, dec_param_valid_in = 0, dec_param_first_in = 0;
  logic enc_param_valid_in, enc_param_first_in, dec_sample_valid_in, dec_sample_first_in;
  logic enc_param_valid_out, enc_homing_detect_out, enc_home_reset_out, enc_in_home_out;
  logic dec_sample_valid_out, dec_homing_detect_out, dec_early_detect_out;
  logic dec_home_reset_out, dec_in_home_out;
  logic [15:0] enc_sample_in = 0, dec_param_in = 0, enc_param_in, dec_sample_in, enc_param_out;
  logic [15:0] enc_lsp_home_out, enc_gain_mem_home_out, dec_sample_out, dec_agc_home_out;
  logic [31:0] noise_seed_out;
  int miscompares = 0, check_count = 0, ne = 0, nd = 0, nx = 0;
  wire [1:0] hr = {dec_home_reset_out, enc_home_reset_out};
  sch_homing i_sch_homing (.*);
  sch_datapath_model i_sch_datapath_model (.clk_in(clk_in), .go_enc_in(go_enc),
    .go_dec_in(go_dec), .enc_param_out(enc_param_in), .enc_param_valid_out(enc_param_valid_in),
    .enc_param_first_out(enc_param_first_in), .dec_sample_out(dec_sample_in),
    .dec_sample_valid_out(dec_sample_valid_in), .dec_sample_first_out(dec_sample_first_in));
  initial forever #2 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    ne <= ne + (enc_homing_detect_out === 1'b1);
    nd <= nd + (dec_homing_detect_out === 1'b1);
    nx <= nx + (dec_early_detect_out === 1'b1);
  end
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // One input frame: odd word at position 80 (enc) or 0 (dec), optional restart at 80
  task automatic frame(input bit dec, input logic [15:0] odd, input bit re, input int nd_exp,
    input int nx_exp);
    ne = 0;
    nd = 0;
    nx = 0;
    for (int i = 0; i < (dec ? 57 : 160); i++) begin
      @(posedge clk_in);
      enc_sample_valid_in <= !dec;
      enc_frame_start_in <= !dec && (i == 0 || (re && i == 80));
      enc_sample_in <= (i == 80) ? odd : sch_pkg::ENC_HOME_WORD;
      dec_param_valid_in <= dec;
      dec_param_first_in <= dec && i == 0;
      dec_param_in <= i ? sch_pkg::DEC_HOME_FRAME[i % 57] : odd;
    end
    @(posedge clk_in);
    enc_sample_valid_in <= 0;
    dec_param_valid_in <= 0;
    enc_sample_in <= 16'hFFF7;
    dec_param_in <= 16'hFFFB;
    repeat (3) @(posedge clk_in);
    check("detect count", dec ? nd : ne, nd_exp);
    check("early count", nx, nx_exp);
    $display("frame done dec=%0d", dec);
  endtask
  // Output stream of a homing frame, then the return to home
  task automatic drain(input bit dec, input logic [15:0] exp);
    int k = 0;
    @(posedge clk_in);
    go_enc <= !dec;
    go_dec <= dec;
    @(posedge clk_in);
    go_enc <= 0;
    go_dec <= 0;
    for (int n = 0; n < 400 && hr[dec] !== 1'b1; n++) begin
      @(negedge clk_in);
      if (dec_sample_valid_out === 1'b1 || enc_param_valid_out === 1'b1) begin
        check("stream word", dec ? dec_sample_out : enc_param_out,
          dec ? exp : sch_pkg::DEC_HOME_FRAME[k % 57]);
        k++;
      end
    end
    if (hr[dec] !== 1'b1) begin
      miscompares++;
      give_verdict;
    end
    check("word count", k, dec ? 160 : 57);
    @(negedge clk_in);
    check("home state", dec ? dec_in_home_out : enc_in_home_out, 1);
    check("home values", dec ? {48'h0, dec_agc_home_out} :
      {noise_seed_out, enc_lsp_home_out, enc_gain_mem_home_out},
      dec ? 64'h1000 : {32'h70816958, 16'h7530, 16'hF6B3});
    $display("drain done dec=%0d", dec);
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 0;
    frame(0, 16'h0008, 0, 1, 0);
    drain(0, 16'h0000);
    frame(0, 16'h0009, 0, 0, 0);
    frame(0, 16'h0008, 1, 0, 0);
    frame(1, 16'h0005, 0, 0, 0);
    frame(1, 16'h0004, 0, 1, 0);
    drain(1, 16'h1234);
    frame(1, 16'h0004, 0, 1, 1);
    drain(1, 16'h0008);
    give_verdict;
  end
endmodule // sch_homing_bench
